// File: hw/tacc_pkg.sv
package tacc_pkg;
   // register word addresses
   localparam logic [9:0] ADDR_CTRL0 = 10'h002;
   localparam logic [9:0] ADDR_CTRL1 = 10'h003;
   localparam logic [9:0] ADDR_CTRL2 = 10'h004;
   localparam logic [9:0] ADDR_LOWEN = 10'h005;
   localparam int         ADDR_W     = 10;
   localparam int         DATA_W     = 16;

   // reset values
   localparam logic [15:0] RST_CTRL0 = 16'h0FF0;
   localparam logic [15:0] RST_CTRL1 = 16'h0140;
   localparam logic [15:0] RST_CTRL2 = 16'hFFFF;
   localparam logic [15:0] RST_LOWEN = 16'h0000;

   // ctrl0 fields
   localparam int SKIP_LSB    = 0;
   localparam int FPCNT_LSB   = 4;
   localparam int LPCNT_LSB   = 8;
   localparam int TMO_LSB     = 12;
   localparam int FORCE_BIT   = 14;
   localparam int RESTART_BIT = 15;
   localparam logic [3:0] SKIP_MAX = 4'hB;
   // ctrl1 fields
   localparam int LVL_LSB  = 0;
   localparam int RATE_LSB = 8;
   localparam int SLOW_LSB = 14;
   // ctrl2 fields
   localparam int FPREC_LSB = 0;
   localparam int LPREC_LSB = 10;
   // lowen fields
   localparam int LOWEN_LSB = 0;
   localparam int PIN_LSB   = 12;
   localparam int TRIG_LSB  = 14;
   localparam logic [15:0] LOWEN_WMASK = 16'hF0FF;

   // multipliers
   localparam int FP_HOLD_MUL = 16;
   localparam int LP_HOLD_MUL = 4;
   localparam int NEAR_MUL    = 16;

   typedef enum logic [1:0] {
      PIN_OFF  = 2'b00,
      PIN_IN   = 2'b01,
      PIN_OUTL = 2'b10,
      PIN_OUTH = 2'b11
   } tacc_pin_e;

   typedef enum logic [1:0] {
      TRIG_LOWLVL  = 2'b00,
      TRIG_RISE    = 2'b01,
      TRIG_FALL    = 2'b10,
      TRIG_HIGHLVL = 2'b11
   } tacc_trig_e;
endpackage

// File: hw/tacc_pin.sv
`timescale 1ns/1ps
module tacc_pin (
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic [1:0] pin_mode,
   input  wire logic [1:0] pin_trig,
   input  wire logic       pin_level,
   input  wire logic       gpio_in,
   output logic            gpio_out,
   output logic            gpio_oe,
   output logic            gpio_event
);
   // edges and levels ignored until the synchroniser holds real pin data
   localparam logic [1:0] FILL_DONE = 2'h3;

   logic       sync1_q, sync1_d, sync2_q, sync2_d, prev_q, prev_d;
   logic [1:0] fill_q, fill_d;

   always_comb begin
      sync1_d = gpio_in;
      sync2_d = sync1_q;
      prev_d  = sync2_q;
      fill_d  = (fill_q == FILL_DONE) ? fill_q : fill_q + 2'h1;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         prev_q  <= 1'b0;
         fill_q  <= 2'h0;
      end else begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         prev_q  <= prev_d;
         fill_q  <= fill_d;
      end
   end

   always_comb begin
      gpio_oe  = (pin_mode == tacc_pkg::PIN_OUTL) ||
                 (pin_mode == tacc_pkg::PIN_OUTH);
      gpio_out = (pin_mode == tacc_pkg::PIN_OUTH) ? pin_level
                                                  : ~pin_level;
      gpio_event = 1'b0;
      if ((pin_mode == tacc_pkg::PIN_IN) && (fill_q == FILL_DONE)) begin
         case (pin_trig)
            tacc_pkg::TRIG_LOWLVL:  gpio_event = ~sync2_q;
            tacc_pkg::TRIG_RISE:    gpio_event = sync2_q & ~prev_q;
            tacc_pkg::TRIG_FALL:    gpio_event = ~sync2_q & prev_q;
            tacc_pkg::TRIG_HIGHLVL: gpio_event = sync2_q;
            default:                gpio_event = 1'b0;
         endcase
      end
   end
endmodule

// File: hw/tacc_regs.sv
// Contract
// - skip field discards N sequences per admitted one; 0 admits all, max 1011
// - full power calibration hold = count x 16 sequences; resets to F
// - low power calibration hold = count x 4 sequences; resets to F
// - power drop timeout = full power count x 1.25/1.5/1.75/2.0
// - forced calibration bit makes every stage recalibrate
// - writing one to restart bit restarts sequence at stage 0, self-clears
// - near recal level field times 16; resets to 64
// - detection rate field times 16; resets to 1
// - two-bit slow filter level, reset zero
// - ten-bit full power recal time, resets all ones
// - six-bit low power recal time, resets all ones
// - per-stage low enables gate low-threshold events onto interrupt
// - pin setup: off, input, active-low output, active-high output
// - input trigger: low level, rising, falling, high level
`timescale 1ns/1ps
module tacc_regs #(
   parameter int STAGES = 8
) (
   input  wire logic                sys_clk,
   input  wire logic                rst,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   input  wire logic [9:0]          reg_addr,
   input  wire logic [15:0]         reg_wdata,
   output logic      [15:0]         reg_rdata,
   input  wire logic                seq_done,
   input  wire logic [STAGES-1:0]   stage_low_hit,
   input  wire logic                pin_level,
   input  wire logic                gpio_in,
   output logic                     gpio_out,
   output logic                     gpio_oe,
   output logic                     gpio_event,
   output logic                     fifo_admit,
   output logic [7:0]               full_power_cal_hold,
   output logic [5:0]               low_power_cal_hold,
   output logic [8:0]               power_drop_timeout,
   output logic                     forced_cal,
   output logic                     sequence_restart,
   output logic [11:0]              near_recal_level,
   output logic [9:0]               near_detect_rate,
   output logic [1:0]               slow_filter_level,
   output logic [9:0]               full_power_near_recal_time,
   output logic [5:0]               low_power_near_recal_time,
   output logic                     low_irq
);
   default clocking chk_cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   // ---------------------------------------------------------------
   // register file
   // ---------------------------------------------------------------
   logic [15:0] ctrl0_q, ctrl0_d, ctrl1_q, ctrl1_d;
   logic [15:0] ctrl2_q, ctrl2_d, lowen_q, lowen_d;
   logic [15:0] rdata_q, rdata_d;
   logic        restart_q, restart_d;
   logic [3:0]  skip_q, skip_d;
   logic        wr0;
   logic [3:0]  skip_cnt;
   logic [1:0]  tmo_code;
   logic [3:0]  fp_cnt;

   assign wr0      = reg_wr && (reg_addr == tacc_pkg::ADDR_CTRL0);
   assign skip_cnt = ctrl0_q[tacc_pkg::SKIP_LSB +: 4];
   assign fp_cnt   = ctrl0_q[tacc_pkg::FPCNT_LSB +: 4];
   assign tmo_code = ctrl0_q[tacc_pkg::TMO_LSB +: 2];

   always_comb begin
      ctrl0_d = ctrl0_q;
      ctrl1_d = ctrl1_q;
      ctrl2_d = ctrl2_q;
      lowen_d = lowen_q;
      // restart bit never stored; self-clears after one cycle
      ctrl0_d[tacc_pkg::RESTART_BIT] = 1'b0;
      restart_d = 1'b0;
      if (reg_wr) begin
         case (reg_addr)
            tacc_pkg::ADDR_CTRL0: begin
               ctrl0_d = reg_wdata;
               ctrl0_d[tacc_pkg::RESTART_BIT] = 1'b0;
               if (reg_wdata[tacc_pkg::SKIP_LSB +: 4] > tacc_pkg::SKIP_MAX)
                  ctrl0_d[tacc_pkg::SKIP_LSB +: 4] = tacc_pkg::SKIP_MAX;
               restart_d = reg_wdata[tacc_pkg::RESTART_BIT];
            end
            tacc_pkg::ADDR_CTRL1: ctrl1_d = reg_wdata;
            tacc_pkg::ADDR_CTRL2: ctrl2_d = reg_wdata;
            tacc_pkg::ADDR_LOWEN:
               lowen_d = reg_wdata & tacc_pkg::LOWEN_WMASK;
            default: ;
         endcase
      end
      case (reg_addr)
         tacc_pkg::ADDR_CTRL0: rdata_d = ctrl0_q;
         tacc_pkg::ADDR_CTRL1: rdata_d = ctrl1_q;
         tacc_pkg::ADDR_CTRL2: rdata_d = ctrl2_q;
         tacc_pkg::ADDR_LOWEN: rdata_d = lowen_q;
         default:              rdata_d = 16'h0000;
      endcase
      if (!reg_rd)
         rdata_d = rdata_q;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ctrl0_q   <= tacc_pkg::RST_CTRL0;
         ctrl1_q   <= tacc_pkg::RST_CTRL1;
         ctrl2_q   <= tacc_pkg::RST_CTRL2;
         lowen_q   <= tacc_pkg::RST_LOWEN;
         rdata_q   <= 16'h0000;
         restart_q <= 1'b0;
      end else begin
         ctrl0_q   <= ctrl0_d;
         ctrl1_q   <= ctrl1_d;
         ctrl2_q   <= ctrl2_d;
         lowen_q   <= lowen_d;
         rdata_q   <= rdata_d;
         restart_q <= restart_d;
      end
   end

   assign reg_rdata = rdata_q;

   // ---------------------------------------------------------------
   // fast filter skip counter
   // ---------------------------------------------------------------
   always_comb begin
      skip_d     = skip_q;
      fifo_admit = 1'b0;
      if (restart_q) begin
         skip_d = 4'h0;
      end else if (seq_done) begin
         if (skip_q == 4'h0) begin
            fifo_admit = 1'b1;
            skip_d     = skip_cnt;
         end else begin
            skip_d = skip_q - 4'h1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst)
         skip_q <= 4'h0;
      else
         skip_q <= skip_d;
   end

   // ---------------------------------------------------------------
   // derived control values
   // ---------------------------------------------------------------
   logic [8:0] tmo_x4;
   always_comb begin
      // timeout in quarter counts: count*(5+code)
      tmo_x4 = 9'({5'h0, fp_cnt} * (9'd5 + 9'(tmo_code)));
   end

   assign full_power_cal_hold = 8'({4'h0, fp_cnt} *
                                    8'(tacc_pkg::FP_HOLD_MUL));
   assign low_power_cal_hold  =
      6'({2'h0, ctrl0_q[tacc_pkg::LPCNT_LSB +: 4]} *
         6'(tacc_pkg::LP_HOLD_MUL));
   assign power_drop_timeout  = tmo_x4;
   assign forced_cal          = ctrl0_q[tacc_pkg::FORCE_BIT];
   assign sequence_restart    = restart_q;
   assign near_recal_level    =
      12'({4'h0, ctrl1_q[tacc_pkg::LVL_LSB +: 8]} *
          12'(tacc_pkg::NEAR_MUL));
   assign near_detect_rate    =
      10'({4'h0, ctrl1_q[tacc_pkg::RATE_LSB +: 6]} *
          10'(tacc_pkg::NEAR_MUL));
   assign slow_filter_level   = ctrl1_q[tacc_pkg::SLOW_LSB +: 2];
   assign full_power_near_recal_time =
      ctrl2_q[tacc_pkg::FPREC_LSB +: 10];
   assign low_power_near_recal_time  =
      ctrl2_q[tacc_pkg::LPREC_LSB +: 6];

   // ---------------------------------------------------------------
   // low threshold enables
   // ---------------------------------------------------------------
   logic [STAGES-1:0] low_gated;
   genvar g;
   generate
      for (g = 0; g < STAGES; g++) begin : g_low
         assign low_gated[g] = stage_low_hit[g] &
                               lowen_q[tacc_pkg::LOWEN_LSB + g];
      end
   endgenerate
   assign low_irq = |low_gated;

   // ---------------------------------------------------------------
   // pin
   // ---------------------------------------------------------------
   tacc_pin u_pin (
      .sys_clk    (sys_clk),
      .rst        (rst),
      .pin_mode   (lowen_q[tacc_pkg::PIN_LSB +: 2]),
      .pin_trig   (lowen_q[tacc_pkg::TRIG_LSB +: 2]),
      .pin_level  (pin_level),
      .gpio_in    (gpio_in),
      .gpio_out   (gpio_out),
      .gpio_oe    (gpio_oe),
      .gpio_event (gpio_event)
   );

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence restart_wr_s;
      wr0 && reg_wdata[tacc_pkg::RESTART_BIT];
   endsequence

   sequence restart_pulse_s;
      sequence_restart ##1 !sequence_restart;
   endsequence

   sequence admit_s;
      seq_done && !restart_q && (skip_q == 4'h0);
   endsequence

   sequence count_down_s;
      seq_done && !restart_q && (skip_q != 4'h0);
   endsequence

   restart_pulse_a: assert property (
      restart_wr_s ##1 !(wr0 && reg_wdata[tacc_pkg::RESTART_BIT])
      |-> restart_pulse_s)
      else $error("restart not a one cycle pulse");

   restart_skip_a: assert property (
      restart_wr_s |=> ##1 (skip_q == 4'h0))
      else $error("restart did not clear skip counter");

   restart_reads_zero_a: assert property (
      !ctrl0_q[tacc_pkg::RESTART_BIT])
      else $error("restart bit read back as one");

   skip_bound_a: assert property (
      skip_cnt <= tacc_pkg::SKIP_MAX)
      else $error("skip count above maximum");

   skip_zero_a: assert property (
      admit_s |-> fifo_admit)
      else $error("zero skip did not admit");

   admit_reload_a: assert property (
      admit_s |=> (skip_q == $past(skip_cnt)))
      else $error("skip counter not reloaded");

   skip_drop_a: assert property (
      count_down_s |-> !fifo_admit ##1 (skip_q == $past(skip_q) - 4'h1))
      else $error("skipped sequence admitted");

   fp_hold_a: assert property (
      full_power_cal_hold == 8'(fp_cnt * tacc_pkg::FP_HOLD_MUL))
      else $error("full power hold wrong");

   lp_hold_a: assert property (
      low_power_cal_hold ==
      6'(ctrl0_q[tacc_pkg::LPCNT_LSB +: 4] * tacc_pkg::LP_HOLD_MUL))
      else $error("low power hold wrong");

   timeout_a: assert property (
      (tmo_code == 2'b11) |-> (power_drop_timeout == 9'(fp_cnt * 8)))
      else $error("timeout scale wrong");

   timeout_min_a: assert property (
      (tmo_code == 2'b00) |-> (power_drop_timeout == 9'(fp_cnt * 5)))
      else $error("shortest timeout scale wrong");

   forced_cal_a: assert property (
      wr0 |=> (forced_cal == $past(reg_wdata[tacc_pkg::FORCE_BIT])))
      else $error("forced calibration not applied");

   near_level_a: assert property (
      near_recal_level ==
      12'(ctrl1_q[tacc_pkg::LVL_LSB +: 8] * tacc_pkg::NEAR_MUL))
      else $error("recal level scale wrong");

   near_rate_a: assert property (
      near_detect_rate ==
      10'(ctrl1_q[tacc_pkg::RATE_LSB +: 6] * tacc_pkg::NEAR_MUL))
      else $error("detect rate scale wrong");

   slow_level_a: assert property (
      reg_wr && (reg_addr == tacc_pkg::ADDR_CTRL1) |=>
      (slow_filter_level == $past(reg_wdata[tacc_pkg::SLOW_LSB +: 2])))
      else $error("slow filter level not written");

   fp_recal_a: assert property (
      reg_wr && (reg_addr == tacc_pkg::ADDR_CTRL2) |=>
      (full_power_near_recal_time ==
       $past(reg_wdata[tacc_pkg::FPREC_LSB +: 10])))
      else $error("full power recal time not written");

   lp_recal_a: assert property (
      reg_wr && (reg_addr == tacc_pkg::ADDR_CTRL2) |=>
      (low_power_near_recal_time ==
       $past(reg_wdata[tacc_pkg::LPREC_LSB +: 6])))
      else $error("low power recal time not written");

   low_mask_a: assert property (
      (lowen_q[7:0] == 8'h00) |-> !low_irq)
      else $error("masked low event raised interrupt");

   low_pass_a: assert property (
      (|(stage_low_hit & lowen_q[tacc_pkg::LOWEN_LSB +: STAGES]))
      |-> low_irq)
      else $error("enabled low event missed");

   unused_zero_a: assert property (
      lowen_q[11:8] == 4'h0)
      else $error("unused enable bits stored");

   pin_oe_a: assert property (
      (lowen_q[13:12] == 2'b01) |-> !gpio_oe)
      else $error("input pin driven");

   pin_high_a: assert property (
      (lowen_q[tacc_pkg::PIN_LSB +: 2] == tacc_pkg::PIN_OUTH)
      |-> gpio_oe && (gpio_out == pin_level))
      else $error("active high output wrong");

   pin_low_a: assert property (
      (lowen_q[tacc_pkg::PIN_LSB +: 2] == tacc_pkg::PIN_OUTL)
      |-> gpio_oe && (gpio_out == !pin_level))
      else $error("active low output wrong");

   pin_quiet_a: assert property (
      (lowen_q[tacc_pkg::PIN_LSB +: 2] != tacc_pkg::PIN_IN)
      |-> !gpio_event)
      else $error("event raised outside input mode");
endmodule

// File: verif/tacc_host.sv
`timescale 1ns/1ps
// ----------------------------------------
// host register access model
// ----------------------------------------
module tacc_host (
   input  wire logic        sys_clk,
   output logic             reg_wr,
   output logic             reg_rd,
   output logic [9:0]       reg_addr,
   output logic [15:0]      reg_wdata,
   input  wire logic [15:0] reg_rdata
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 10'h000;
      reg_wdata = 16'h0000;
   end

   task automatic wr(input logic [9:0] a, input logic [15:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      reg_wdata = (a == 10'h005) ? (d & 16'hf0ff) : d;
      reg_wr = 1'b1;
      @(negedge sys_clk);
      reg_wr = 1'b0;
      // released data no longer shows the last word
      reg_wdata = ~reg_wdata;
   endtask

   task automatic rd(input logic [9:0] a, output logic [15:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge sys_clk);
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask
endmodule

// File: verif/touch_ambient_comp_ctrl_regs_bench.sv
`timescale 1ns/1ps
module touch_ambient_comp_ctrl_regs_bench;
   localparam logic [7:0] LOW_EN = 8'ha5;
   logic        sys_clk;
   logic        rst;
   logic        reg_wr;
   logic        reg_rd;
   logic [9:0]  reg_addr;
   logic [15:0] reg_wdata;
   logic [15:0] reg_rdata;
   logic        seq_done;
   logic [7:0]  stage_low_hit;
   logic        pin_level;
   logic        gpio_in;
   logic        gpio_out;
   logic        gpio_oe;
   logic        gpio_event;
   logic        fifo_admit;
   logic [7:0]  fp_hold;
   logic [5:0]  lp_hold;
   logic [8:0]  tmo;
   logic        forced_cal;
   logic        restart;
   logic [11:0] lvl;
   logic [9:0]  rate;
   logic [1:0]  slow;
   logic [9:0]  fprec;
   logic [5:0]  lprec;
   logic        low_irq;
   logic [15:0] rd_v;
   logic [31:0] n;
   int          n_fail;
   int          tests_run;

   tacc_regs #(.STAGES(8)) DUT (.sys_clk(sys_clk), .rst(rst),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .seq_done(seq_done),
      .stage_low_hit(stage_low_hit), .pin_level(pin_level),
      .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
      .gpio_event(gpio_event), .fifo_admit(fifo_admit),
      .full_power_cal_hold(fp_hold), .low_power_cal_hold(lp_hold),
      .power_drop_timeout(tmo), .forced_cal(forced_cal),
      .sequence_restart(restart), .near_recal_level(lvl),
      .near_detect_rate(rate), .slow_filter_level(slow),
      .full_power_near_recal_time(fprec),
      .low_power_near_recal_time(lprec), .low_irq(low_irq));

   tacc_host host (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // ----------------------------------------
   // compare and verdict
   // ----------------------------------------
   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset;
      host.rd(10'h002, rd_v);
      check("ctrl0", rd_v, 16'h0ff0);
      host.rd(10'h003, rd_v);
      check("ctrl1", rd_v, 16'h0140);
      host.rd(10'h004, rd_v);
      check("ctrl2", rd_v, 16'hffff);
      host.rd(10'h005, rd_v);
      check("lowen", rd_v, 16'h0000);
      host.rd(10'h006, rd_v);
      check("unmapped", rd_v, 16'h0000);
      check("fp_hold", fp_hold, 8'hf0);
      check("lp_hold", lp_hold, 6'h3c);
      check("tmo", tmo, 9'h04b);
      check("lvl", lvl, 12'h400);
      check("rate", rate, 10'h010);
      check("slow", slow, 2'h0);
      check("fprec", fprec, 10'h3ff);
      check("lprec", lprec, 6'h3f);
   endtask

   task automatic t_ctrl0;
      for (int c = 0; c < 4; c++) begin
         host.wr(10'h002, {2'b01, c[1:0], 12'hf35});
         check("tmo", tmo, 9'(3 * (5 + c)));
         host.rd(10'h002, rd_v);
         check("ctrl0", rd_v, {2'b01, c[1:0], 12'hf35});
      end
      check("fp_hold", fp_hold, 8'h30);
      check("lp_hold", lp_hold, 6'h3c);
      check("force", forced_cal, 1'b1);
      host.wr(10'h002, 16'h000f);
      check("force", forced_cal, 1'b0);
      host.rd(10'h002, rd_v);
      check("skip_max", rd_v, 16'h000b);
   endtask

   task automatic t_restart;
      host.wr(10'h002, 16'h8000);
      check("restart", restart, 1'b1);
      @(negedge sys_clk);
      check("restart", restart, 1'b0);
      host.rd(10'h002, rd_v);
      check("restart_rd", rd_v, 16'h0000);
   endtask

   task automatic t_skip(input logic [3:0] s);
      host.wr(10'h002, {12'h800, s});
      repeat (2) @(negedge sys_clk);
      n = 0;
      repeat (3 * (s + 1)) begin
         @(negedge sys_clk);
         seq_done = 1'b1;
         #1;
         n += 32'(fifo_admit);
         @(negedge sys_clk);
         seq_done = 1'b0;
      end
      check("admits", n, 3);
   endtask

   task automatic t_ctrl12;
      host.wr(10'h003, 16'hffff);
      check("lvl", lvl, 12'hff0);
      check("rate", rate, 10'h3f0);
      check("slow", slow, 2'h3);
      host.wr(10'h004, 16'h5a5a);
      check("fprec", fprec, 10'h25a);
      check("lprec", lprec, 6'h16);
      host.rd(10'h004, rd_v);
      check("ctrl2", rd_v, 16'h5a5a);
   endtask

   task automatic t_low_irq;
      host.wr(10'h005, {8'h00, LOW_EN});
      for (int i = 0; i < 8; i++) begin
         @(negedge sys_clk);
         stage_low_hit = 8'h01 << i;
         #1;
         check("low_irq", low_irq, LOW_EN[i]);
      end
      @(negedge sys_clk);
      stage_low_hit = 8'h00;
   endtask

   task automatic t_pin_out;
      for (int m = 0; m < 4; m++) begin
         host.wr(10'h005, {2'b00, m[1:0], 12'h000});
         for (int p = 0; p < 2; p++) begin
            @(negedge sys_clk);
            pin_level = p[0];
            #1;
            check("oe", gpio_oe, m[1]);
            if (m[1]) begin
               check("out", gpio_out, m[0] ? p[0] : !p[0]);
            end
         end
      end
   endtask

   task automatic t_pin_in;
      for (int t = 0; t < 4; t++) begin
         host.wr(10'h005, {t[1:0], 2'b01, 12'h000});
         gpio_in = !t[0];
         repeat (6) @(negedge sys_clk);
         check("idle_evt", gpio_event, 1'b0);
         gpio_in = t[0];
         n = 0;
         repeat (8) begin
            @(negedge sys_clk);
            n += 32'(gpio_event);
         end
         if (t == 1 || t == 2) begin
            check("edge_evt", n, 1);
         end else begin
            check("lvl_evt", gpio_event, 1'b1);
         end
      end
   endtask

   task automatic t_mid_reset;
      host.wr(10'h004, 16'h0000);
      @(negedge sys_clk);
      rst = 1'b1;
      repeat (2) @(negedge sys_clk);
      rst = 1'b0;
      check("fprec_rst", fprec, 10'h3ff);
      check("lprec_rst", lprec, 6'h3f);
      check("rdata_rst", reg_rdata, 16'h0000);
      check("restart_rst", restart, 1'b0);
      host.rd(10'h005, rd_v);
      check("lowen_rst", rd_v, 16'h0000);
      check("oe_rst", gpio_oe, 1'b0);
   endtask

   initial begin
      rst = 1'b1;
      seq_done = 1'b0;
      stage_low_hit = 8'h00;
      pin_level = 1'b0;
      gpio_in = 1'b0;
      n_fail = 0;
      tests_run = 0;
      repeat (20) @(posedge sys_clk);
      @(negedge sys_clk);
      rst = 1'b0;
      t_reset;
      t_ctrl0;
      t_restart;
      t_skip(4'h0);
      t_skip(4'h2);
      t_skip(4'hb);
      t_ctrl12;
      t_low_irq;
      t_pin_out;
      t_pin_in;
      t_mid_reset;
      end_sim;
   end

   // run needs well under 1000 cycles
   initial begin
      #50000;
      n_fail++;
      end_sim;
   end
endmodule
